// [hw/tsl_trigger_sequencer_limits.v]
// trigger sequencer limits: broadcast enables, step delay, counter-0 limit, AXI4-Lite slave
// Function
// - broadcast command pulses ADC trigger outputs 15..12 for each set enable bit 15..12
// - broadcast command pulses capture 4..1 sync for each set enable bit 11..8
// - broadcast command pulses compare 4..1 clock for each set enable bit 7..4
// - broadcast enables used only by control step with option 1111
// - step delay limit counts extra sequencer clocks from step start to completion
// - each step lasts step delay limit plus one clock
// - counter-0 limit supplies the loop count of jump-on-counter-0 step
// - counter-0 limit also serves as terminal limit of general counter 0
// - all three registers ignore writes while enabled, started and stepping
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "tsl_defs.vh"
module tsl_trigger_sequencer_limits (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // step commands from the decoder (same clock)
  input wire stepStart,
  input wire [3:0] ctrlOption,
  input wire isCtrlCmd,
  input wire jump0Cmd,
  input wire counter0Tick,
  // step and loop results
  output reg stepDone,
  output reg stepBusy,
  output reg jump0Taken,
  output reg counter0Limit,
  // peripheral pulses
  output reg [3:0] adcTrigger,
  output reg [3:0] captureSync,
  output reg [3:0] compareClock,
  output reg [3:0] compareSync
);

  // register state
  reg [15:0] bte_r;
  reg [15:0] sdLim_r;
  reg [15:0] c0Lim_r;
  reg enable_r;
  reg start_r;
  reg [16:0] delayCnt_r;
  reg [15:0] loopCnt_r;
  reg [15:0] gpCnt_r;
  reg [7:0] awAddr_r;
  reg awHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHeld_r;

  // byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = old;
      if (strb[0]) merge16[7:0] = data[7:0];
      if (strb[1]) merge16[15:8] = data[15:8];
    end
  endfunction

  // address to one-hot register select; zero for an unmapped offset
  function [4:0] regSel;
    input [7:0] a;
    begin
      case (a)
        `TSL_OFF_BTE: regSel = 5'h01;
        `TSL_OFF_SDLIM: regSel = 5'h02;
        `TSL_OFF_C0LIM: regSel = 5'h04;
        `TSL_OFF_CTRL: regSel = 5'h08;
        `TSL_OFF_STAT: regSel = 5'h10;
        default: regSel = 5'h00;
      endcase
    end
  endfunction

  // address decode, shared by both channels
  function mapped;
    input [7:0] a;
    begin
      mapped = (regSel(a) != 5'h00);
    end
  endfunction

  // address and data are each held until both are present; one write in flight
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire [7:0] wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  wire [31:0] wrData = wHeld_r ? wData_r : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  wire wrGo = (awHeld_r || awFire) && (wHeld_r || wFire);

  // locked while running; a blocked write still answers okay but changes nothing
  wire locked = enable_r && start_r && stepBusy;
  wire bcast = stepStart && isCtrlCmd && (ctrlOption == `TSL_OPT_BCAST);

  // enable fields of the broadcast register, one nibble per peripheral group
  wire [3:0] adcEn = bte_r[`TSL_BTE_ADC_HI:`TSL_BTE_ADC_LO];
  wire [3:0] captureEn = bte_r[`TSL_BTE_IC_HI:`TSL_BTE_IC_LO];
  wire [3:0] compareClkEn = bte_r[`TSL_BTE_OCCK_HI:`TSL_BTE_OCCK_LO];
  wire [3:0] compareSyncEn = bte_r[`TSL_BTE_OCSY_HI:`TSL_BTE_OCSY_LO];
  // read-back words of the control and status registers
  wire [31:0] ctrlWord = {30'h00000000, start_r, enable_r};
  wire [31:0] statWord = {29'h00000000, locked, counter0Limit, stepBusy};

  // write channel capture and response
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (wrGo) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wrAddr) ? `TSL_RESP_OKAY : `TSL_RESP_SLVERR;
      end else begin
        if (awFire) begin
          awHeld_r <= 1'b1;
          awAddr_r <= s_axi_awaddr;
        end
        if (wFire) begin
          wHeld_r <= 1'b1;
          wData_r <= s_axi_wdata;
          wStrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // next values of the software registers
  reg [15:0] bte_nxt;
  reg [15:0] sdLim_nxt;
  reg [15:0] c0Lim_nxt;
  reg enable_nxt;
  reg start_nxt;
  wire [4:0] wrSel = regSel(wrAddr);

  // the limits refuse writes while locked; control stays writable so a run can be stopped
  always @* begin
    bte_nxt = bte_r;
    sdLim_nxt = sdLim_r;
    c0Lim_nxt = c0Lim_r;
    enable_nxt = enable_r;
    start_nxt = start_r;
    if (wrGo && !locked) begin
      if (wrSel[0]) bte_nxt = merge16(bte_r, wrData, wrStrb);
      if (wrSel[1]) sdLim_nxt = merge16(sdLim_r, wrData, wrStrb);
      if (wrSel[2]) c0Lim_nxt = merge16(c0Lim_r, wrData, wrStrb);
    end
    if (wrGo && wrSel[3] && wrStrb[0]) begin
      enable_nxt = wrData[`TSL_CTRL_EN];
      start_nxt = wrData[`TSL_CTRL_START];
    end
  end

  // software registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bte_r <= `TSL_RST_BTE;
      sdLim_r <= `TSL_RST_SDLIM;
      c0Lim_r <= `TSL_RST_C0LIM;
      enable_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      bte_r <= bte_nxt;
      sdLim_r <= sdLim_nxt;
      c0Lim_r <= c0Lim_nxt;
      enable_r <= enable_nxt;
      start_r <= start_nxt;
    end
  end

  // read data of the addressed register; unmapped offsets read as zero
  reg [31:0] rdWord;
  always @* begin
    case (s_axi_araddr)
      `TSL_OFF_BTE: rdWord = {16'h0000, bte_r};
      `TSL_OFF_SDLIM: rdWord = {16'h0000, sdLim_r};
      `TSL_OFF_C0LIM: rdWord = {16'h0000, c0Lim_r};
      `TSL_OFF_CTRL: rdWord = ctrlWord;
      `TSL_OFF_STAT: rdWord = statWord;
      default: rdWord = 32'h00000000;
    endcase
  end

  // read channel, one cycle after the address is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `TSL_RESP_OKAY : `TSL_RESP_SLVERR;
      s_axi_rdata <= rdWord;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // step timer next state: a start is ignored while enable is low or a step runs
  reg stepBusy_nxt;
  reg stepDone_nxt;
  reg [16:0] delayCnt_nxt;
  always @* begin
    stepBusy_nxt = stepBusy;
    stepDone_nxt = 1'b0;
    delayCnt_nxt = delayCnt_r;
    if (!enable_r) begin
      stepBusy_nxt = 1'b0;
    end else if (stepStart && !stepBusy) begin
      stepBusy_nxt = 1'b1;
      delayCnt_nxt = {1'b0, sdLim_r} + `TSL_BASE_DELAY;
    end else if (stepBusy) begin
      if (delayCnt_r == 17'h00001) begin
        stepBusy_nxt = 1'b0;
        stepDone_nxt = 1'b1;
      end
      delayCnt_nxt = delayCnt_r - 17'h00001;
    end
  end

  // step timer: done pulses sdLim+1 clocks after the start edge, as busy falls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stepBusy <= 1'b0;
      stepDone <= 1'b0;
      delayCnt_r <= 17'h00000;
    end else begin
      stepBusy <= stepBusy_nxt;
      stepDone <= stepDone_nxt;
      delayCnt_r <= delayCnt_nxt;
    end
  end

  // pulse values for the next clock; every field stays quiet without a broadcast
  wire [3:0] adcTrigger_nxt = bcast ? adcEn : 4'h0;
  wire [3:0] captureSync_nxt = bcast ? captureEn : 4'h0;
  wire [3:0] compareClock_nxt = bcast ? compareClkEn : 4'h0;
  wire [3:0] compareSync_nxt = bcast ? compareSyncEn : 4'h0;

  // broadcast pulses, one clock wide, gated by the enable fields
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adcTrigger <= 4'h0;
      captureSync <= 4'h0;
      compareClock <= 4'h0;
      compareSync <= 4'h0;
    end else begin
      adcTrigger <= adcTrigger_nxt;
      captureSync <= captureSync_nxt;
      compareClock <= compareClock_nxt;
      compareSync <= compareSync_nxt;
    end
  end

  // jump-0 loop next state: jump until the count meets the limit, then reload
  reg [15:0] loopCnt_nxt;
  reg jump0Taken_nxt;
  always @* begin
    loopCnt_nxt = loopCnt_r;
    jump0Taken_nxt = 1'b0;
    if (!enable_r) begin
      loopCnt_nxt = 16'h0000;
    end else if (stepStart && jump0Cmd) begin
      if (loopCnt_r == c0Lim_r) begin
        loopCnt_nxt = 16'h0000;
      end else begin
        loopCnt_nxt = loopCnt_r + 16'h0001;
        jump0Taken_nxt = 1'b1;
      end
    end
  end

  // jump-0 loop registers; a limit of zero never jumps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loopCnt_r <= 16'h0000;
      jump0Taken <= 1'b0;
    end else begin
      loopCnt_r <= loopCnt_nxt;
      jump0Taken <= jump0Taken_nxt;
    end
  end

  // general counter 0 next state; stops counting once the terminal flag is up
  reg [15:0] gpCnt_nxt;
  reg counter0Limit_nxt;
  always @* begin
    gpCnt_nxt = gpCnt_r;
    counter0Limit_nxt = counter0Limit;
    if (!enable_r) begin
      gpCnt_nxt = 16'h0000;
      counter0Limit_nxt = 1'b0;
    end else if (counter0Tick && !counter0Limit) begin
      gpCnt_nxt = gpCnt_r + 16'h0001;
      counter0Limit_nxt = (gpCnt_r + 16'h0001) == c0Lim_r;
    end
  end

  // general counter 0 registers; the flag is a level until enable is cleared
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpCnt_r <= 16'h0000;
      counter0Limit <= 1'b0;
    end else begin
      gpCnt_r <= gpCnt_nxt;
      counter0Limit <= counter0Limit_nxt;
    end
  end

endmodule

// [hw/tsl_defs.vh]
// register map, field positions and reset values of the trigger sequencer limits block
`ifndef TSL_DEFS_VH
`define TSL_DEFS_VH
`define TSL_ADDR_W 8
`define TSL_OFF_BTE 8'h00
`define TSL_OFF_SDLIM 8'h04
`define TSL_OFF_C0LIM 8'h08
`define TSL_OFF_CTRL 8'h0C
`define TSL_OFF_STAT 8'h10
`define TSL_RST_BTE 16'h0000
`define TSL_RST_SDLIM 16'h0000
`define TSL_RST_C0LIM 16'h0000
`define TSL_BASE_DELAY 17'h00001
`define TSL_BTE_ADC_HI 15
`define TSL_BTE_ADC_LO 12
`define TSL_BTE_IC_HI 11
`define TSL_BTE_IC_LO 8
`define TSL_BTE_OCCK_HI 7
`define TSL_BTE_OCCK_LO 4
`define TSL_BTE_OCSY_HI 3
`define TSL_BTE_OCSY_LO 0
`define TSL_CTRL_EN 0
`define TSL_CTRL_START 1
`define TSL_OPT_BCAST 4'hF
`define TSL_RESP_OKAY 2'b00
`define TSL_RESP_SLVERR 2'b10
`endif

// [testbench/tsl_periph_model.sv]
// sticky record of the pulses that reach the capture, compare and converter units
`timescale 1ns/1ps
module tsl_periph_model (
  // clock, reset and clear
  input wire clk,
  input wire rst_n,
  input wire clr,
  // pulses from the sequencer
  input wire [3:0] adcTrigger,
  input wire [3:0] captureSync,
  input wire [3:0] compareClock,
  input wire [3:0] compareSync,
  // every unit that was hit since the last clear
  output logic [15:0] seen
);
  // pulses last one cycle, so keep them until the bench clears
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) seen <= 16'h0000;
    else if (clr) seen <= 16'h0000;
    else seen <= seen | {adcTrigger, captureSync, compareClock, compareSync};
  end
endmodule

// [testbench/tsl_seq_chk.sv]
// port assertions of the trigger sequencer limits block
`timescale 1ns/1ps
module tsl_seq_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // write handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // step commands
  input wire stepStart,
  input wire [3:0] ctrlOption,
  input wire isCtrlCmd,
  input wire jump0Cmd,
  input wire counter0Tick,
  // results and pulses
  input wire stepDone,
  input wire stepBusy,
  input wire jump0Taken,
  input wire counter0Limit,
  input wire [3:0] adcTrigger,
  input wire [3:0] captureSync,
  input wire [3:0] compareClock,
  input wire [3:0] compareSync
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  bcast_only_a:
    assert property (!(stepStart && isCtrlCmd && ctrlOption == 4'hF) |=>
      {adcTrigger, captureSync, compareClock, compareSync} == 16'h0000) else $error("stray pulse");
  done_busy_a:
    assert property (stepDone |-> !stepBusy && $past(stepBusy)) else $error("done while idle");
  done_end_a:
    assert property (stepDone |=> !stepDone) else $error("step overruns");
  busy_cause_a:
    assert property ($rose(stepBusy) |-> $past(stepStart)) else $error("busy without start");
  jump_cause_a:
    assert property (jump0Taken |-> $past(stepStart && jump0Cmd)) else $error("stray jump");
  lim_cause_a:
    assert property ($rose(counter0Limit) |-> $past(counter0Tick)) else $error("limit no tick");
  wr_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      s_axi_bvalid) else $error("late write answer");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
endmodule

// [testbench/tb_top.sv]
// self-checking bench of the trigger sequencer limits block
`timescale 1ns/1ps
`include "tsl_defs.vh"
module tb_top;
  logic clk = 1'h0, rst_n = 1'h0, clr = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, ctrlOption = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, stepStart = 1'h0, isCtrlCmd = 1'h0;
  logic jump0Cmd = 1'h0, counter0Tick = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, jt;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  logic stepDone, stepBusy, jump0Taken, counter0Limit;
  logic [3:0] adcTrigger, captureSync, compareClock, compareSync;
  logic [15:0] seen;
  int nFail = 0, cmpCount = 0, n;
  always #5 clk = ~clk;
  tsl_trigger_sequencer_limits dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stepStart, .ctrlOption, .isCtrlCmd, .jump0Cmd,
    .counter0Tick, .stepDone, .stepBusy, .jump0Taken, .counter0Limit, .adcTrigger,
    .captureSync, .compareClock, .compareSync);
  tsl_periph_model pm (.clk, .rst_n, .clr, .adcTrigger, .captureSync, .compareClock,
    .compareSync, .seen);
  task automatic chk(input string nm, input [31:0] g, e);
    cmpCount++;
    if (g !== e) begin
      nFail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input [7:0] a, input [31:0] v);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end while (!(ta && tw));
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'h0;
    br = s_axi_bresp;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // one-cycle step start, then the cycles until done are counted in n
  task automatic go(input c, input [3:0] o, input j);
    @(posedge clk);
    {stepStart, isCtrlCmd, ctrlOption, jump0Cmd} <= {1'h1, c, o, j};
    @(posedge clk);
    stepStart <= 1'h0;
    #1 jt = jump0Taken;
    n = 0;
    while (stepDone !== 1'h1 && n < 99) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic bc(input c, input [3:0] o, input [15:0] e);
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    go(c, o, 1'h0);
    chk("broadcast", seen, e);
  endtask
  task automatic tRegs;
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i));
      chk("reset value", d, 32'h0);
    end
    rd(8'h40);
    chk("unmapped read", rr, `TSL_RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk("unmapped write", br, `TSL_RESP_SLVERR);
  endtask
  task automatic tBcast;
    wr(`TSL_OFF_CTRL, 32'h1);
    wr(`TSL_OFF_BTE, 32'hA5C3);
    bc(1'h1, 4'hF, 16'hA5C3);
    chk("base delay", n, 32'h1);
    bc(1'h1, 4'hE, 16'h0000);
    bc(1'h0, 4'hF, 16'h0000);
  endtask
  task automatic tStep;
    wr(`TSL_OFF_SDLIM, 32'h3);
    go(1'h0, 4'h0, 1'h0);
    chk("step delay", n, 32'h4);
  endtask
  // writes while the step runs are dropped; afterwards they land again
  task automatic tLock;
    wr(`TSL_OFF_CTRL, 32'h3);
    wr(`TSL_OFF_SDLIM, 32'h1E);
    @(posedge clk);
    stepStart <= 1'h1;
    @(posedge clk);
    stepStart <= 1'h0;
    wr(`TSL_OFF_BTE, 32'h1234);
    wr(`TSL_OFF_SDLIM, 32'h5);
    rd(`TSL_OFF_BTE);
    chk("locked enable", d, 32'hA5C3);
    rd(`TSL_OFF_STAT);
    chk("lock status", d, 32'h5);
    repeat (30) @(posedge clk);
    rd(`TSL_OFF_SDLIM);
    chk("locked delay", d, 32'h1E);
    wr(`TSL_OFF_BTE, 32'h1234);
    rd(`TSL_OFF_BTE);
    chk("idle write", d, 32'h1234);
  endtask
  task automatic tJump;
    wr(`TSL_OFF_CTRL, 32'h1);
    wr(`TSL_OFF_SDLIM, 32'h0);
    wr(`TSL_OFF_C0LIM, 32'h2);
    for (int i = 0; i < 3; i++) begin
      go(1'h0, 4'h0, 1'h1);
      chk("loop jump", jt, i < 2);
    end
    for (int i = 1; i < 3; i++) begin
      @(posedge clk);
      counter0Tick <= 1'h1;
      @(posedge clk);
      counter0Tick <= 1'h0;
      repeat (2) @(posedge clk);
      #1 chk("counter limit", counter0Limit, i == 2);
    end
  endtask
  task automatic summarize;
    if (nFail == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // enable (and, in the lock test, start) is raised before the limits are loaded
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    tRegs;
    tBcast;
    tStep;
    tLock;
    tJump;
    summarize;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #50000;
    nFail++;
    summarize;
  end
endmodule
bind tsl_trigger_sequencer_limits tsl_seq_chk chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .stepStart, .ctrlOption,
  .isCtrlCmd, .jump0Cmd, .counter0Tick, .stepDone, .stepBusy, .jump0Taken, .counter0Limit,
  .adcTrigger, .captureSync, .compareClock, .compareSync);
